// *** src/ptg_map.svh ***
/*
 * Register indices, field positions, reset values and timing counts
 * of the transmit timing and gain block.
 * Assumes a 250 MHz core clock; each register index is one bus word.
 */
// Behaviour
// - Every transmitted sample is multiplied by the global gain and cut to 16 bits.
// - Global gain 0xFF passes the amplitude unchanged and 0x00 zeroes it.
// - Each preamble sample is multiplied by the preamble gain and cut to 16 bits.
// - Preamble gain 0xFF passes the chirp unchanged and 0x00 zeroes it.
// - Each sample outside the preamble is scaled by the body gain and cut to 16 bits.
// - Body gain 0xFF passes the body unchanged and 0x00 zeroes it.
// - A writable 20-bit send time in 10 us units names when the next frame leaves.
// - The send time sits in the top 20 bits of a 32-bit view, low 12 bits read zero.
// - Once the arm bit is cleared, sending starts only when the counter equals the send time.
// - A received preamble copies the time counter into the read-only timestamp.
// - The timestamp sits in the top 20 bits of a 32-bit view, low 12 bits read zero.
// - The time counter steps every 10 us from 0 to 1048575 and wraps to 0.
// - The time counter is read-only and shown in the top 20 bits of a 32-bit view.
// - The arm bit reads one while sending is pending and zero once it has begun.
`ifndef PTG_MAP_SVH
`define PTG_MAP_SVH
`define PTG_IDX_GLOBAL 16'hFE24
`define PTG_IDX_SCHED 16'hFE26
`define PTG_IDX_STATUS 16'hFE2A
`define PTG_IDX_STAMP 16'hFE2D
`define PTG_IDX_TIMER 16'hFE47
`define PTG_IDX_PRE 16'hFE9B
`define PTG_IDX_BODY 16'hFE9C
`define PTG_GAIN_RST 8'hFF
`define PTG_GAIN_UNITY 8'hFF
`define PTG_ARM_BIT 2
`define PTG_TICK_NS 10000
`define PTG_CLK_NS 4
`define PTG_TICK_CYC (`PTG_TICK_NS / `PTG_CLK_NS)
`endif

// *** src/ptg_pkg.sv ***
/*
 * Types shared by the transmit timing and gain block.
 * Assumes the constants header is compiled alongside.
 */
package ptg_pkg;
	typedef enum logic [2:0]
	{
		PTG_IDLE = 3'b001,
		PTG_WAIT = 3'b010,
		PTG_SEND = 3'b100
	} ptg_state_e;
	typedef logic [19:0] ptg_time_t;
	typedef logic [7:0] ptg_gain_t;
endpackage

// *** src/ptg_timing_gain.sv ***
/*
 * Time base, scheduled send, receive timestamp and transmit sample
 * scaling, with an Avalon-MM slave that exposes one byte per word.
 * Assumes inputs synchronous to clock_i and a well-behaved bus master.
 */
`timescale 1ns/1ns
`include "ptg_map.svh"
// Full scale is a true bypass; the plain product would lose one part
// in 256 and could never give back a positive input exactly.
module ptg_scale_stage
	import ptg_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input wire logic [WIDTH-1:0] x_i,
	input wire logic [7:0] gain_i,
	output logic [WIDTH-1:0] y_o
);
	logic signed [WIDTH+8:0] prod;

	always_comb
	begin
		prod = $signed(x_i) * $signed({1'b0, gain_i});
		if (gain_i == `PTG_GAIN_UNITY)
			y_o = x_i;
		else
			y_o = prod[WIDTH+7:8];
	end
endmodule

module ptg_timing_gain
	import ptg_pkg::*;
#(
	parameter int TICK_CYCLES = `PTG_TICK_CYC,
	parameter int DEPTH = 2
)
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [17:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic rx_preamble_i,
	input wire logic s_valid_i,
	output logic s_ready_o,
	input wire logic [15:0] s_data_i,
	input wire logic s_chirp_i,
	input wire logic s_last_i,
	output logic m_valid_o,
	input wire logic m_ready_i,
	output logic [15:0] m_data_o,
	output logic m_last_o,
	output logic tx_start_o,
	output logic tx_busy_o
);
	ptg_state_e state;
	ptg_time_t time_cnt;
	ptg_time_t sched;
	ptg_time_t stamp;
	logic [7:0] stage_hi;
	logic [7:0] stage_mid;
	logic [11:0] tick_cnt;
	ptg_gain_t global_gain;
	ptg_gain_t pre_gain;
	ptg_gain_t body_gain;
	ptg_gain_t lat_global;
	ptg_gain_t lat_pre;
	ptg_gain_t lat_body;
	logic sent;
	logic ack;
	logic [15:0] idx;
	logic wr_do;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic start;
	logic in_fire;
	logic out_fire;
	logic [15:0] scaled;
	ptg_gain_t sect_gain;
	logic [15:0] sect_scaled;
	logic tick_done;
	logic arm_wr;
	logic [16:0] mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] wr_ptr;
	logic [$clog2(DEPTH)-1:0] rd_ptr;
	logic [$clog2(DEPTH):0] count;

	function automatic logic [7:0] view(input ptg_time_t v,
		input logic [1:0] sel);
		logic [31:0] w;
		w = {v, 12'h000};
		case (sel)
			2'h0: view = w[31:24];
			2'h1: view = w[23:16];
			2'h2: view = w[15:8];
			default: view = w[7:0];
		endcase
	endfunction

	assign idx = avs_address_i[17:2];
	assign wbyte = avs_writedata_i[7:0];
	assign wr_do = avs_write_i & ack & avs_byteenable_i[0];
	assign arm_wr = wr_do && (idx == `PTG_IDX_STATUS);
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

	// Bus answer: one wait cycle, then the access completes.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			ack <= 1'b0;
		else
			ack <= (avs_read_i | avs_write_i) & ~ack;
	end

	always_comb
	begin
		rbyte = 8'h00;
		case (idx)
			`PTG_IDX_GLOBAL: rbyte = global_gain;
			`PTG_IDX_PRE: rbyte = pre_gain;
			`PTG_IDX_BODY: rbyte = body_gain;
			`PTG_IDX_STATUS: rbyte = {5'h00, ~sent, 2'h0};
			// Time views are spelled out byte by byte, most significant first.
			`PTG_IDX_SCHED: rbyte = view(sched, 2'h0);
			`PTG_IDX_SCHED + 16'h1: rbyte = view(sched, 2'h1);
			`PTG_IDX_SCHED + 16'h2: rbyte = view(sched, 2'h2);
			`PTG_IDX_SCHED + 16'h3: rbyte = view(sched, 2'h3);
			`PTG_IDX_STAMP: rbyte = view(stamp, 2'h0);
			`PTG_IDX_STAMP + 16'h1: rbyte = view(stamp, 2'h1);
			`PTG_IDX_STAMP + 16'h2: rbyte = view(stamp, 2'h2);
			`PTG_IDX_STAMP + 16'h3: rbyte = view(stamp, 2'h3);
			`PTG_IDX_TIMER: rbyte = view(time_cnt, 2'h0);
			`PTG_IDX_TIMER + 16'h1: rbyte = view(time_cnt, 2'h1);
			`PTG_IDX_TIMER + 16'h2: rbyte = view(time_cnt, 2'h2);
			`PTG_IDX_TIMER + 16'h3: rbyte = view(time_cnt, 2'h3);
			default: rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && !ack)
			avs_readdata_o <= {24'h000000, rbyte};
	end

	// Gain registers.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			global_gain <= `PTG_GAIN_RST;
		else if (wr_do && idx == `PTG_IDX_GLOBAL)
			global_gain <= wbyte;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			pre_gain <= `PTG_GAIN_RST;
		else if (wr_do && idx == `PTG_IDX_PRE)
			pre_gain <= wbyte;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			body_gain <= `PTG_GAIN_RST;
		else if (wr_do && idx == `PTG_IDX_BODY)
			body_gain <= wbyte;
	end

	// The upper bytes wait in a stage and the compare value only changes
	// on the third byte, so a half-written time never triggers a send.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			stage_hi <= 8'h00;
		else if (wr_do && idx == `PTG_IDX_SCHED)
			stage_hi <= wbyte;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			stage_mid <= 8'h00;
		else if (wr_do && idx == `PTG_IDX_SCHED + 16'h1)
			stage_mid <= wbyte;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			sched <= 20'h00000;
		else if (wr_do && idx == `PTG_IDX_SCHED + 16'h2)
			sched <= {stage_hi, stage_mid, wbyte[7:4]};
	end

	// Time base; the wrap past the top count comes free from the add.
	assign tick_done = (tick_cnt == 12'(TICK_CYCLES - 1));

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			tick_cnt <= 12'h000;
		else if (tick_done)
			tick_cnt <= 12'h000;
		else
			tick_cnt <= tick_cnt + 12'h001;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			time_cnt <= 20'h00000;
		else if (tick_done)
			time_cnt <= time_cnt + 20'h00001;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			stamp <= 20'h00000;
		else if (rx_preamble_i)
			stamp <= time_cnt;
	end

	// Send scheduling.
	assign start = (state == PTG_WAIT) && (time_cnt == sched);

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			state <= PTG_IDLE;
		else
		begin
			case (state)
				PTG_IDLE:
				begin
					if (arm_wr && !wbyte[`PTG_ARM_BIT])
						state <= PTG_WAIT;
				end
				PTG_WAIT:
				begin
					if (start)
						state <= PTG_SEND;
					else if (arm_wr && wbyte[`PTG_ARM_BIT])
						state <= PTG_IDLE;
				end
				PTG_SEND:
				begin
					if (in_fire && s_last_i)
						state <= PTG_IDLE;
				end
				default:
				begin
					state <= PTG_IDLE;
				end
			endcase
		end
	end

	// Start wins over a simultaneous write, so a begun send is never hidden.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			sent <= 1'b0;
		else if (start)
			sent <= 1'b1;
		else if (arm_wr && state == PTG_IDLE && !wbyte[`PTG_ARM_BIT])
			sent <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			lat_global <= `PTG_GAIN_RST;
		else if (start)
			lat_global <= global_gain;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			lat_pre <= `PTG_GAIN_RST;
		else if (start)
			lat_pre <= pre_gain;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			lat_body <= `PTG_GAIN_RST;
		else if (start)
			lat_body <= body_gain;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			tx_start_o <= 1'b0;
		else
			tx_start_o <= start;
	end

	assign tx_busy_o = (state == PTG_SEND);

	// Section gain first, then global; both stages are combinational, so
	// a sample enters the buffer in the cycle in which it is taken.
	assign sect_gain = s_chirp_i ? lat_pre : lat_body;

	ptg_scale_stage #(.WIDTH(16)) i_sect_scale
	(
		.x_i(s_data_i),
		.gain_i(sect_gain),
		.y_o(sect_scaled)
	);

	ptg_scale_stage #(.WIDTH(16)) i_global_scale
	(
		.x_i(sect_scaled),
		.gain_i(lat_global),
		.y_o(scaled)
	);

	assign s_ready_o = (state == PTG_SEND) && (count != DEPTH);
	assign in_fire = s_valid_i & s_ready_o;
	assign m_valid_o = (count != 0);
	assign out_fire = m_valid_o & m_ready_i;
	assign m_data_o = mem[rd_ptr][15:0];
	assign m_last_o = mem[rd_ptr][16];

	// Two entries let the sink stall for a cycle without losing a word.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= 17'h00000;
		end
		else if (in_fire)
			mem[wr_ptr] <= {s_last_i, scaled};
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			wr_ptr <= '0;
		else if (in_fire)
			wr_ptr <= wr_ptr + 1'b1;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			rd_ptr <= '0;
		else if (out_fire)
			rd_ptr <= rd_ptr + 1'b1;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			count <= '0;
		else if (in_fire && !out_fire)
			count <= count + 1'b1;
		else if (out_fire && !in_fire)
			count <= count - 1'b1;
	end
endmodule

// *** dv/ptg_sink.sv ***
/* Converter-side sink of the transmit sample stream.
   Assumes the bench collects the samples that it accepts. */
`timescale 1ns/1ns
module ptg_sink
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	output logic m_ready_o
);
	logic [2:0] phase;
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			phase <= 3'h0;
		else
			phase <= phase + 3'h1;
	end
	// Slow for four cycles (ready only in the fourth), then prompt for four, so that the buffer fills up.
	assign m_ready_o = rst_b_i && (phase[2] || phase[1:0] == 2'h3);
endmodule

// *** dv/ptg_timing_gain_asserts.sv ***
/* Port checker of the timing and gain block.
   Assumes it is bound to ptg_timing_gain with one clock. */
`timescale 1ns/1ns
module ptg_timing_gain_asserts #(parameter int DEPTH = 2)
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic s_valid_i,
	input wire logic s_ready_o,
	input wire logic s_last_i,
	input wire logic m_valid_o,
	input wire logic m_ready_i,
	input wire logic [15:0] m_data_o,
	input wire logic m_last_o,
	input wire logic tx_start_o,
	input wire logic tx_busy_o
);
	logic [2:0] occ;
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			occ <= 3'h0;
		else
			occ <= occ + 3'(s_valid_i && s_ready_o)
				- 3'(m_valid_o && m_ready_i);
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence req_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence push;
		s_valid_i && s_ready_o;
	endsequence
	AST_BUS_ACK: assert property (req_wait |=> !avs_waitrequest_o)
		else $error("bus request not answered in one cycle");
	AST_RD_PAD: assert property (avs_readdata_o[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	AST_IDLE: assert property (!tx_busy_o |-> !s_ready_o)
		else $error("sample taken while not sending");
	AST_START: assert property ($rose(tx_busy_o) |-> ##[0:1] tx_start_o)
		else $error("no start pulse at send start");
	AST_PULSE: assert property (tx_start_o |=> !tx_start_o)
		else $error("start pulse too long");
	AST_HOLD: assert property (m_valid_o && !m_ready_i |=>
		m_valid_o && $stable(m_data_o) && $stable(m_last_o))
		else $error("output sample changed under stall");
	AST_LAT: assert property (push |=> m_valid_o)
		else $error("accepted sample not offered");
	AST_FULL: assert property (s_ready_o |-> occ < DEPTH)
		else $error("ready while buffer full");
	AST_END: assert property (push ##0 s_last_i |=> !tx_busy_o)
		else $error("burst did not end on last sample");
endmodule
bind ptg_timing_gain ptg_timing_gain_asserts #(.DEPTH(DEPTH))
	i_ptg_timing_gain_asserts (.clock_i, .rst_b_i, .avs_read_i,
	.avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .s_valid_i,
	.s_ready_o, .s_last_i, .m_valid_o, .m_ready_i, .m_data_o,
	.m_last_o, .tx_start_o, .tx_busy_o);

// *** dv/ptg_timing_gain_tb.sv ***
/* Self-checking bench of the timing and gain block.
   Assumes the sink model and the checker are compiled alongside. */
`timescale 1ns/1ns
`include "ptg_map.svh"
module ptg_timing_gain_tb import ptg_pkg::*;;
	logic clock_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0;
	logic avs_write_i = 1'b0, rx_preamble_i = 1'b0, s_valid_i = 1'b0;
	logic s_chirp_i = 1'b0, s_last_i = 1'b0;
	logic [17:0] avs_address_i = 18'h0;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic [15:0] s_data_i = 16'h0, m_data_o;
	logic [16:0] exp_q[$], got_q[$];
	logic avs_waitrequest_o, s_ready_o, m_valid_o, m_ready_i, m_last_o;
	logic tx_start_o, tx_busy_o;
	int bad_count = 0, total_checks = 0;
	always #2 clock_i = ~clock_i;
	ptg_timing_gain #(.TICK_CYCLES(4)) i_ptg_timing_gain (.clock_i,
		.rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .rx_preamble_i, .s_valid_i, .s_ready_o,
		.s_data_i, .s_chirp_i, .s_last_i, .m_valid_o, .m_ready_i,
		.m_data_o, .m_last_o, .tx_start_o, .tx_busy_o);
	ptg_sink i_ptg_sink (.clock_i, .rst_b_i, .m_ready_o(m_ready_i));
	always @(posedge clock_i)
		if (m_valid_o && m_ready_i)
			got_q.push_back({m_last_o, m_data_o});
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] ix,
		input logic [7:0] d, input logic [3:0] be, output logic [7:0] q);
		@(posedge clock_i);
		avs_address_i <= {ix, 2'b00};
		avs_writedata_i <= {24'h0, d};
		avs_byteenable_i <= be;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge clock_i);
		while (avs_waitrequest_o)
			@(posedge clock_i);
		q = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic wrb(input logic [15:0] ix, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, ix, d, 4'hF, q);
	endtask
	task automatic rdc(input logic [15:0] ix, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, ix, 8'h0, 4'hF, q);
		chk(q, e);
	endtask
	// Expected samples are worked out by hand from the gains of each burst.
	task automatic put(input logic [15:0] x, input logic ch, last,
		input logic [15:0] e);
		@(posedge clock_i);
		s_valid_i <= 1'b1;
		s_data_i <= x;
		s_chirp_i <= ch;
		s_last_i <= last;
		exp_q.push_back({last, e});
		@(posedge clock_i);
		while (!s_ready_o)
			@(posedge clock_i);
		s_valid_i <= 1'b0;
	endtask
	task automatic regs();
		logic [7:0] q;
		rdc(`PTG_IDX_PRE, 8'hFF);
		rdc(`PTG_IDX_BODY, 8'hFF);
		rdc(16'hFE00, 8'h00);
		bus(1'b1, `PTG_IDX_GLOBAL, 8'h12, 4'h0, q);
		rdc(`PTG_IDX_GLOBAL, 8'hFF);
		wrb(`PTG_IDX_TIMER, 8'h55);
		rdc(`PTG_IDX_TIMER, 8'h00);
		wrb(`PTG_IDX_STAMP, 8'h55);
		rdc(`PTG_IDX_STAMP, 8'h00);
	endtask
	task automatic burst(input ptg_gain_t gg, gp, gb, input logic [7:0] t,
		input logic [15:0] e0, e1, e2, e3);
		wrb(`PTG_IDX_GLOBAL, gg);
		wrb(`PTG_IDX_PRE, gp);
		wrb(`PTG_IDX_BODY, gb);
		wrb(`PTG_IDX_SCHED, 8'h00);
		wrb(`PTG_IDX_SCHED + 16'h1, t);
		wrb(`PTG_IDX_SCHED + 16'h2, 8'h00);
		rdc(`PTG_IDX_SCHED + 16'h1, t);
		rdc(`PTG_IDX_SCHED + 16'h3, 8'h00);
		wrb(`PTG_IDX_STATUS, 8'h00);
		rdc(`PTG_IDX_STATUS, 8'h04);
		chk(tx_busy_o, 1'b0);
		while (!tx_busy_o)
			@(posedge clock_i);
		rdc(`PTG_IDX_TIMER + 16'h1, t);
		rdc(`PTG_IDX_STATUS, 8'h00);
		rx_preamble_i <= 1'b1;
		@(posedge clock_i);
		rx_preamble_i <= 1'b0;
		rdc(`PTG_IDX_STAMP + 16'h1, t);
		rdc(`PTG_IDX_STAMP + 16'h3, 8'h00);
		put(16'h7FFF, 1'b1, 1'b0, e0);
		put(16'h8001, 1'b1, 1'b0, e1);
		wrb(`PTG_IDX_BODY, ~gb);
		put(16'h1234, 1'b0, 1'b0, e2);
		put(16'hFEDC, 1'b0, 1'b1, e3);
		while (got_q.size() < exp_q.size())
			@(posedge clock_i);
		while (exp_q.size() > 0)
			chk(got_q.pop_front(), exp_q.pop_front());
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clock_i);
		bad_count++;
		test_done();
	end
	initial
	begin
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		regs();
		burst(8'h80, 8'hFF, 8'h00, 8'h10, 16'h3FFF, 16'hC000, 16'h0000,
			16'h0000);
		burst(8'hFF, 8'h40, 8'hFF, 8'h20, 16'h1FFF, 16'hE000, 16'h1234,
			16'hFEDC);
		test_done();
	end
endmodule
